// [dv/hf_oscillator_control_test.sv]
`timescale 1ns/1ps
module hf_oscillator_control_test;
   logic       clk_sys, rst, sfr_wr, sfr_rd, rd_q;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
   logic [1:0] clock_source_select;
   logic       port0_match, port1_match, cmp0_enable, cmp0_out;
   logic       timer3_overflow, wake_timer_tick;
   logic       hf_osc_run, hf_freq_ready, wake_timer_sync_busy;
   logic       cpu_stall, system_clock_en;
   logic [7:0] exp_q[$];
   int         error_cnt, compares, seed;
   localparam logic [7:0] A = hfoc_pkg::ADDR_CTRL;

   hfoc_ctrl #(.SETTLE(4)) dut (.clk_sys(clk_sys), .rst(rst),
      .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .clock_source_select(clock_source_select),
      .port0_match(port0_match), .port1_match(port1_match),
      .cmp0_enable(cmp0_enable), .cmp0_out(cmp0_out),
      .timer3_overflow(timer3_overflow), .wake_timer_tick(wake_timer_tick),
      .hf_osc_run(hf_osc_run), .hf_freq_ready(hf_freq_ready),
      .wake_timer_sync_busy(wake_timer_sync_busy), .cpu_stall(cpu_stall),
      .system_clock_en(system_clock_en));

   // 50 ns period
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic finish_test;
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : finish_test

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      sfr_addr  <= a;
      sfr_wdata <= d;
      sfr_wr    <= 1'b1;
      @(posedge clk_sys);
      sfr_wr    <= 1'b0;
   endtask : wr

   // expected value queued now, compared when the answer shows
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      sfr_addr <= a;
      sfr_rd   <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk_sys);
      sfr_rd   <= 1'b0;
   endtask : rd

   // pulses over 16 cycles; phase-free since 16 is a multiple of 8
   task automatic count_pulses(input logic [7:0] e);
      logic [7:0] c;
      c = 8'h00;
      repeat (16) begin
         @(posedge clk_sys);
         c = c + {7'h00, system_clock_en};
      end
      check(c, e);
   endtask : count_pulses

   task automatic wake(input int s);
      @(posedge clk_sys);
      case (s)
         0: port0_match <= 1'b1;
         1: port1_match <= 1'b1;
         2: begin
            cmp0_enable <= 1'b1;
            cmp0_out    <= 1'b0;
         end
         default: timer3_overflow <= 1'b1;
      endcase
      @(posedge clk_sys);
      {port0_match, port1_match, timer3_overflow, cmp0_enable} <= 4'h0;
      cmp0_out <= 1'b1;
   endtask : wake

   // read answers arrive one cycle after the read edge
   always @(posedge clk_sys) begin
      if (rd_q) check(sfr_rdata, exp_q.pop_front());
      rd_q <= sfr_rd;
   end

   // watchdog, far beyond the few hundred cycles needed
   initial begin
      repeat (5000) @(posedge clk_sys);
      error_cnt++;
      finish_test();
   end

   initial begin
      {rst, rd_q, sfr_wr, sfr_rd} = 4'h8;
      {sfr_addr, sfr_wdata, clock_source_select} = 18'h0;
      {port0_match, port1_match, cmp0_enable, timer3_overflow} = 4'h0;
      {cmp0_out, wake_timer_tick} = 2'b10;
      {error_cnt, compares, seed} = {32'h0, 32'h0, 32'd31};
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      rd(A, hfoc_pkg::CTRL_RESET);
      for (int d = 0; d < 4; d++) begin
         wr(A, 8'h80 | d[7:0] | 8'($random(seed) & 8'h0c));
         rd(A, 8'hc0 | d[7:0]);
         count_pulses(8'h02 << d);
      end
      clock_source_select <= 2'h1;
      count_pulses(8'h00);
      clock_source_select <= 2'h0;
      // other address is ignored and reads zero
      wr(8'hb3, 8'h00);
      rd(8'hb3, 8'h00);
      rd(A, 8'hc3);
      wr(A, 8'h00);
      rd(A, 8'h00);
      check({7'h0, hf_osc_run}, 8'h00);
      wr(A, 8'h80);
      rd(A, 8'h80);
      repeat (6) @(posedge clk_sys);
      rd(A, 8'hc0);
      for (int s = 0; s < 4; s++) begin
         wr(A, 8'ha0 | 8'($random(seed) & 8'h0c));
         rd(A, 8'ha0);
         check({7'h0, cpu_stall}, 8'h01);
         check({7'h0, hf_freq_ready}, 8'h00);
         // comparator low while disabled must not wake
         cmp0_out <= 1'b0;
         @(posedge clk_sys);
         cmp0_out <= 1'b1;
         rd(A, 8'ha0);
         wake(s);
         rd(A, (s == 3) ? 8'h80 : 8'h90);
         check({7'h0, wake_timer_sync_busy}, (s == 3) ? 8'h00 : 8'h01);
         // even passes tick back to back, odd passes every other cycle
         repeat (3) begin
            @(posedge clk_sys);
            wake_timer_tick <= 1'b1;
            if (s[0]) begin
               @(posedge clk_sys);
               wake_timer_tick <= 1'b0;
            end
         end
         @(posedge clk_sys);
         wake_timer_tick <= 1'b0;
         rd(A, 8'hc0);
         check({7'h0, cpu_stall}, 8'h00);
         check({7'h0, hf_freq_ready}, 8'h01);
         check({7'h0, wake_timer_sync_busy}, 8'h00);
      end
      repeat (3) @(posedge clk_sys);
      finish_test();
   end
endmodule : hf_oscillator_control_test

// [verilog/hfoc_ctrl.sv]
`timescale 1ns/1ps
// Behaviour
// - enable bit 7 runs the oscillator when 1; resets to 1
// - ready flag bit 6 is 1 only while running at programmed frequency
// - writing suspend bit 5 while running at frequency halts oscillator; any wake event restarts it
// - sync flag bit 4 busy up to three timer clocks after non-timer wake
// - bits 3:2 read zero and ignore writes
// - divider field 00/01/10/11 divides by 8/4/2/1; resets 00
// - wake on port 0 match, port 1 match, comparator 0 low, timer 3 overflow
// - processor resumes at next instruction after suspend write
// - scaled oscillator is system clock when source select is 00
module hfoc_ctrl #(
   parameter int SETTLE = hfoc_pkg::SETTLE_CYCLES
) (
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic [7:0] sfr_addr,
   input  wire logic       sfr_wr,
   input  wire logic       sfr_rd,
   input  wire logic [7:0] sfr_wdata,
   output logic      [7:0] sfr_rdata,
   input  wire logic [1:0] clock_source_select,
   input  wire logic       port0_match,
   input  wire logic       port1_match,
   input  wire logic       cmp0_enable,
   input  wire logic       cmp0_out,
   input  wire logic       timer3_overflow,
   input  wire logic       wake_timer_tick,
   output logic            hf_osc_run,
   output logic            hf_freq_ready,
   output logic            wake_timer_sync_busy,
   output logic            cpu_stall,
   output logic            system_clock_en
);
   typedef struct packed {
      hfoc_pkg::hfoc_mode_t mode;
      logic                 enable;
      logic [1:0]           divider;
      logic [3:0]           settle_cnt;
      logic [1:0]           sync_cnt;
      logic                 sync_busy;
      logic [7:0]           rdata;
   } hfoc_state_t;

   hfoc_state_t state_reg;
   hfoc_state_t state_next;
   logic        wr_hit;
   logic        any_wake;
   logic        other_wake;
   logic [7:0]  ctrl_view;
   logic        ps_pulse;

   assign wr_hit = sfr_wr && (sfr_addr == hfoc_pkg::ADDR_CTRL);
   // wake sources; comparator counts only while enabled
   assign other_wake = port0_match | port1_match
                     | (cmp0_enable & ~cmp0_out);
   assign any_wake = other_wake | timer3_overflow;

   // register view; bits 3:2 stay zero
   always_comb begin
      ctrl_view = 8'h00;
      ctrl_view[hfoc_pkg::BIT_ENABLE]    = state_reg.enable;
      ctrl_view[hfoc_pkg::BIT_READY]     = (state_reg.mode == hfoc_pkg::HFOC_RUN);
      ctrl_view[hfoc_pkg::BIT_SUSPEND]   =
         (state_reg.mode == hfoc_pkg::HFOC_SUSPENDED);
      ctrl_view[hfoc_pkg::BIT_SYNC_BUSY] = state_reg.sync_busy;
      ctrl_view[hfoc_pkg::DIV_LSB +: 2]  = state_reg.divider;
   end

   // next state: register writes, oscillator mode, sync window
   always_comb begin
      state_next = state_reg;
      state_next.rdata = sfr_rd && (sfr_addr == hfoc_pkg::ADDR_CTRL)
                       ? ctrl_view : 8'h00;
      if (wr_hit) begin
         state_next.enable  = sfr_wdata[hfoc_pkg::BIT_ENABLE];
         state_next.divider = sfr_wdata[hfoc_pkg::DIV_LSB +: 2];
      end
      // sync window counts timer clocks, cleared after three
      if (state_reg.sync_busy && wake_timer_tick) begin
         if (state_reg.sync_cnt == 2'(hfoc_pkg::SYNC_TIMER_CLKS - 1)) begin
            state_next.sync_busy = 1'b0;
            state_next.sync_cnt  = 2'h0;
         end else begin
            state_next.sync_cnt = state_reg.sync_cnt + 2'h1;
         end
      end
      case (state_reg.mode)
         hfoc_pkg::HFOC_OFF: begin
            if (state_next.enable) begin
               state_next.mode       = hfoc_pkg::HFOC_SETTLE;
               state_next.settle_cnt = 4'h0;
            end
         end
         hfoc_pkg::HFOC_SETTLE: begin
            if (!state_next.enable) begin
               state_next.mode = hfoc_pkg::HFOC_OFF;
            end else if (state_reg.settle_cnt == 4'(SETTLE - 1)) begin
               state_next.mode = hfoc_pkg::HFOC_RUN;
            end else begin
               state_next.settle_cnt = state_reg.settle_cnt + 4'h1;
            end
         end
         hfoc_pkg::HFOC_RUN: begin
            if (!state_next.enable) begin
               state_next.mode = hfoc_pkg::HFOC_OFF;
            end else if (wr_hit && sfr_wdata[hfoc_pkg::BIT_SUSPEND]) begin
               state_next.mode = hfoc_pkg::HFOC_SUSPENDED;
            end
         end
         hfoc_pkg::HFOC_SUSPENDED: begin
            // only wake events leave suspend; no clock reaches software
            if (any_wake) begin
               state_next.mode       = hfoc_pkg::HFOC_SETTLE;
               state_next.settle_cnt = 4'h0;
               if (!timer3_overflow) begin
                  state_next.sync_busy = 1'b1;
                  state_next.sync_cnt  = 2'h0;
               end
            end
         end
         default: state_next.mode = hfoc_pkg::HFOC_OFF;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_reg.mode       <= hfoc_pkg::HFOC_RUN;
         state_reg.enable     <= hfoc_pkg::CTRL_RESET[hfoc_pkg::BIT_ENABLE];
         state_reg.divider    <= hfoc_pkg::DIV_RESET;
         state_reg.settle_cnt <= 4'h0;
         state_reg.sync_cnt   <= 2'h0;
         state_reg.sync_busy  <= 1'b0;
         state_reg.rdata      <= 8'h00;
      end else begin
         state_reg <= state_next;
      end
   end

   hfoc_postscaler u_postscaler (
      .clk_sys     (clk_sys),
      .rst         (rst),
      .run         (hf_osc_run),
      .divider_sel (state_reg.divider),
      .clk_pulse   (ps_pulse)
   );

   assign sfr_rdata            = state_reg.rdata;
   assign hf_osc_run           = (state_reg.mode == hfoc_pkg::HFOC_SETTLE)
                               | (state_reg.mode == hfoc_pkg::HFOC_RUN);
   assign hf_freq_ready        = (state_reg.mode == hfoc_pkg::HFOC_RUN);
   assign wake_timer_sync_busy = state_reg.sync_busy;
   // cpu holds its place; released once the mode is back at HFOC_RUN after the wake and settling
   assign cpu_stall            = (state_reg.mode != hfoc_pkg::HFOC_RUN)
                               && (clock_source_select ==
                                   hfoc_pkg::SRC_HF_OSC);
   // gating with source select keeps other sources untouched
   assign system_clock_en      = ps_pulse && (clock_source_select ==
                                   hfoc_pkg::SRC_HF_OSC);

   a_ready_reset: assert property (@(posedge clk_sys)
      $fell(rst) |-> hf_freq_ready)
      else $error("ready not set after reset");
   a_suspend_halt: assert property (@(posedge clk_sys)
      disable iff (rst)
      (hf_freq_ready && sfr_wr && sfr_addr == hfoc_pkg::ADDR_CTRL
       && sfr_wdata[hfoc_pkg::BIT_ENABLE]
       && sfr_wdata[hfoc_pkg::BIT_SUSPEND]) |=> !hf_osc_run)
      else $error("suspend did not halt oscillator");
   // wake seen while suspended
   sequence s_susp_wake;
      (state_reg.mode == hfoc_pkg::HFOC_SUSPENDED) ##0 any_wake;
   endsequence
   a_wake_restart: assert property (@(posedge clk_sys)
      disable iff (rst)
      s_susp_wake |=> hf_osc_run)
      else $error("wake did not restart oscillator");
   // non-timer wake must open the sync window
   sequence s_other_wake;
      (state_reg.mode == hfoc_pkg::HFOC_SUSPENDED) ##0 other_wake
         ##0 !timer3_overflow;
   endsequence
   a_sync_set: assert property (@(posedge clk_sys)
      disable iff (rst)
      s_other_wake |=> wake_timer_sync_busy)
      else $error("sync flag not raised after wake");
   a_timer_nosync: assert property (@(posedge clk_sys)
      disable iff (rst)
      (state_reg.mode == hfoc_pkg::HFOC_SUSPENDED && timer3_overflow
       && !wake_timer_sync_busy) |=> !wake_timer_sync_busy)
      else $error("timer wake raised sync flag");
   a_disable_stop: assert property (@(posedge clk_sys)
      disable iff (rst)
      (sfr_wr && sfr_addr == hfoc_pkg::ADDR_CTRL
       && !sfr_wdata[hfoc_pkg::BIT_ENABLE])
      |=> !hf_osc_run && !hf_freq_ready)
      else $error("disable did not stop oscillator");
   a_unused_zero: assert property (@(posedge clk_sys)
      disable iff (rst)
      sfr_rdata[3:2] == 2'h0)
      else $error("unused bits not zero");
   // ticks in consecutive cycles must close the window after three
   a_sync_bound: assert property (@(posedge clk_sys)
      disable iff (rst)
      (wake_timer_sync_busy && wake_timer_tick)[*3] |=> !wake_timer_sync_busy)
      else $error("sync flag too long");
   a_div1_pulse: assert property (@(posedge clk_sys)
      disable iff (rst)
      (hf_osc_run && state_reg.divider == 2'h3)[*2] |-> ##1 ps_pulse)
      else $error("divide by one missing pulse");
   // divide by eight: a pulse, seven quiet cycles, then the next pulse
   sequence s_div8_start;
      ps_pulse && hf_osc_run && state_reg.divider == 2'h0;
   endsequence
   sequence s_div8_hold;
      (hf_osc_run && state_reg.divider == 2'h0)[*7];
   endsequence
   a_div8_quiet: assert property (@(posedge clk_sys)
      disable iff (rst)
      s_div8_start ##1 (hf_osc_run && state_reg.divider == 2'h0)
      |-> !ps_pulse)
      else $error("divide by eight pulsed early");
   a_div8_period: assert property (@(posedge clk_sys)
      disable iff (rst)
      s_div8_start ##1 s_div8_hold |=> ps_pulse)
      else $error("divide by eight missed pulse");
   // other sources must see neither pulses nor a stalled cpu
   a_src_gate: assert property (@(posedge clk_sys)
      disable iff (rst)
      clock_source_select != hfoc_pkg::SRC_HF_OSC
      |-> !system_clock_en && !cpu_stall)
      else $error("clock leaked from other source");
endmodule : hfoc_ctrl

// [verilog/hfoc_pkg.sv]
package hfoc_pkg;
   // special-function register address and field layout
   localparam logic [7:0] ADDR_CTRL       = 8'hb2;
   localparam int         BIT_ENABLE      = 7;
   localparam int         BIT_READY       = 6;
   localparam int         BIT_SUSPEND     = 5;
   localparam int         BIT_SYNC_BUSY   = 4;
   localparam int         DIV_LSB         = 0;
   localparam logic [7:0] CTRL_RESET      = 8'hc0;
   localparam logic [1:0] DIV_RESET       = 2'h0;
   localparam logic [1:0] SRC_HF_OSC      = 2'h0;
   // wake-timer clocks that the sync flag may stay busy
   localparam int         SYNC_TIMER_CLKS = 3;
   // oscillator cycles from enable until frequency is steady
   localparam int         SETTLE_CYCLES   = 4;
   // oscillator state
   typedef enum logic [1:0] {
      HFOC_OFF,
      HFOC_SETTLE,
      HFOC_RUN,
      HFOC_SUSPENDED
   } hfoc_mode_t;
endpackage : hfoc_pkg

// [verilog/hfoc_postscaler.sv]
`timescale 1ns/1ps
// divides the oscillator by 8, 4, 2 or 1 as an enable pulse train
module hfoc_postscaler (
   input  wire logic       clk_sys,
   input  wire logic       rst,
   input  wire logic       run,
   input  wire logic [1:0] divider_sel,
   output logic            clk_pulse
);
   typedef struct packed {
      logic [2:0] cnt;
      logic       pulse;
   } hfoc_ps_t;

   hfoc_ps_t state_reg;
   hfoc_ps_t state_next;

   // terminal count per encoding: 00->7, 01->3, 10->1, 11->0
   function automatic logic [2:0] hfoc_term(input logic [1:0] sel);
      case (sel)
         2'h0:    hfoc_term = 3'h7;
         2'h1:    hfoc_term = 3'h3;
         2'h2:    hfoc_term = 3'h1;
         default: hfoc_term = 3'h0;
      endcase
   endfunction : hfoc_term

   // counter freezes while stopped so no pulse leaks out
   always_comb begin
      state_next = state_reg;
      state_next.pulse = 1'b0;
      if (run) begin
         if (state_reg.cnt >= hfoc_term(divider_sel)) begin
            state_next.cnt   = 3'h0;
            state_next.pulse = 1'b1;
         end else begin
            state_next.cnt = state_reg.cnt + 3'h1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign clk_pulse = state_reg.pulse;
endmodule : hfoc_postscaler
